/* inc/dewc_defs.svh */
// Constants of the data EEPROM write control block
//
// Behaviour
// - Program start counts only right after arming
// - Start without arm does nothing
// - Async timer ends cycle, start bit clears
// - Cycle end also clears the arm bit
// - Byte write erases first, then programs
// - Page mode programs up to sixteen bytes
// - Buffer cleared at reset and arm fall
// - Six page bits, four offset bits
// - Page data write fills buffer, bumps offset
// - Offset stops at 0fh, then writes ignored
// - Arm bit cleared at power-on
// - Sector pointers reset; control needs sector 1
// - Erase or program end sets irq flag
// - Vector taken only when all gates open
// - Servicing the interrupt clears the flag
// - Erase starts only right after wipe arm
// - Read: arm, start, start clears, data valid
// - Mode bit picks page or byte operation
// - Wipe zeroes buffered bytes only; wipe start clears
`ifndef DEWC_DEFS_SVH
`define DEWC_DEFS_SVH

// ****************************************
// Address layout
// ****************************************
`define DEWC_ADDR_W      10
`define DEWC_OFS_W       4
`define DEWC_PAGE_BYTES  16
`define DEWC_OFS_LAST    4'hf
`define DEWC_HIGH_W      2

// ****************************************
// Control register bit positions
// ****************************************
`define DEWC_B_WIPE_ARM  6
`define DEWC_B_WIPE_GO   5
`define DEWC_B_MODE      4
`define DEWC_B_PROG_ARM  3
`define DEWC_B_PROG_GO   2
`define DEWC_B_FETCH_ARM 1
`define DEWC_B_FETCH_GO  0

// ****************************************
// Reset value and control sector
// ****************************************
`define DEWC_RST_BYTE    8'h00
`define DEWC_CTRL_SECTOR 8'h01

`endif

/* inc/dewc_pkg.sv */
// Types of the data EEPROM write control block
package dewc_pkg;

    typedef enum logic [1:0] {
        DEWC_IDLE,
        DEWC_RUN,
        DEWC_DROP
    } dewc_state_t;

    typedef enum logic [1:0] {
        DEWC_OP_BYTE_ERASE,
        DEWC_OP_BYTE_PROG,
        DEWC_OP_PAGE_PROG,
        DEWC_OP_PAGE_WIPE
    } dewc_op_t;

endpackage

/* src/dewc_core.sv */
// Data EEPROM write, erase and read control with its storage array
`timescale 1ns/10ps
`default_nettype none
`include "dewc_defs.svh"

module dewc_core
    import dewc_pkg::*;
#(
    parameter int DEPTH = 1024
)
(
    // Clock and reset
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    // CPU register writes, one instruction per clock
    input  wire logic [7:0] i_wdata,
    input  wire logic       i_addr_high_wr,
    input  wire logic       i_addr_low_wr,
    input  wire logic       i_data_wr,
    input  wire logic       i_ctrl_wr,
    input  wire logic       i_ctrl_via_alt,
    input  wire logic       i_sector_wr,
    input  wire logic       i_alt_sector_wr,
    // Interrupt controller side
    input  wire logic       i_nv_irq_enable,
    input  wire logic       i_mf_irq_enable,
    input  wire logic       i_global_irq_gate,
    input  wire logic       i_stack_full,
    input  wire logic       i_irq_ack,
    // Asynchronous program timer
    input  wire logic       i_timer_done,
    output logic            o_timer_run,
    // Register contents seen by the CPU
    output logic [7:0]      o_nv_addr_high,
    output logic [7:0]      o_nv_addr_low,
    output logic [7:0]      o_nv_data_reg,
    output logic [7:0]      o_nv_control_reg,
    output logic [7:0]      o_sector_pointer_high,
    output logic [7:0]      o_alt_sector_pointer_high,
    // Status and interrupt
    output logic            o_busy,
    output logic            o_nv_irq_flag,
    output logic            o_irq_vector
);

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] mem [DEPTH];
    logic [7:0] page_buf [`DEWC_PAGE_BYTES];
    logic [`DEWC_PAGE_BYTES-1:0] buf_tag;

    // ****************************************
    // Registers
    // ****************************************
    logic [`DEWC_HIGH_W-1:0] addr_high;
    logic [7:0]              addr_low;
    logic [7:0]              data_reg;
    logic [7:0]              sector;
    logic [7:0]              alt_sector;
    logic                    ofs_sat;
    logic                    wipe_arm;
    logic                    wipe_go;
    logic                    page_mode;
    logic                    prog_arm;
    logic                    prog_go;
    logic                    fetch_arm;
    logic                    fetch_go;
    logic                    prog_arm_fresh;
    logic                    wipe_arm_fresh;
    logic                    prog_arm_q;
    logic                    wipe_arm_q;
    logic                    irq_flag;

    // ****************************************
    // Sequencer and timer crossing
    // ****************************************
    dewc_state_t state;
    dewc_op_t    op;
    logic        again;
    logic        done_s1;
    logic        done_s2;
    logic        done_q;
    logic        done_rise;
    logic        cyc_end;
    logic        ctrl_we;
    logic        arm_fall;
    logic        page_wr;
    logic [3:0]  ofs;
    logic [9:0]  full_addr;

    assign ofs       = addr_low[`DEWC_OFS_W-1:0];
    assign full_addr = {addr_high, addr_low};

    // Control register needs sector 1 in the pointer used
    assign ctrl_we = i_ctrl_wr && (state == DEWC_IDLE)
                     && ((i_ctrl_via_alt ? alt_sector : sector)
                         == `DEWC_CTRL_SECTOR);

    assign done_rise = done_s2 && !done_q;
    assign cyc_end   = (state == DEWC_RUN) && done_rise
                       && (op != DEWC_OP_BYTE_ERASE);
    assign arm_fall  = (prog_arm_q && !prog_arm)
                       || (wipe_arm_q && !wipe_arm);
    assign page_wr   = i_data_wr && page_mode && !ofs_sat
                       && (state == DEWC_IDLE);

    // Page address with the offset replaced
    function automatic logic [9:0] page_addr(
        input logic [9:0] base,
        input logic [3:0] idx
    );
        page_addr = {base[9:4], idx};
    endfunction

    // ****************************************
    // Timer end crossing
    // ****************************************
    // The timer runs from its own oscillator; only the second stage
    // and its delayed copy are ever looked at.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            done_s1 <= 1'b0;
            done_s2 <= 1'b0;
            done_q  <= 1'b0;
        end
        else
        begin
            done_s1 <= i_timer_done;
            done_s2 <= done_s1;
            done_q  <= done_s2;
        end
    end

    // ****************************************
    // Sector pointers
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            sector     <= `DEWC_RST_BYTE;
            alt_sector <= `DEWC_RST_BYTE;
        end
        else
        begin
            if (i_sector_wr)
                sector <= i_wdata;
            if (i_alt_sector_wr)
                alt_sector <= i_wdata;
        end
    end

    // ****************************************
    // Address registers
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            addr_high <= '0;
            addr_low  <= `DEWC_RST_BYTE;
            ofs_sat   <= 1'b0;
        end
        else if (state == DEWC_IDLE)
        begin
            if (i_addr_high_wr)
                addr_high <= i_wdata[`DEWC_HIGH_W-1:0];
            if (i_addr_low_wr)
            begin
                addr_low <= i_wdata;
                ofs_sat  <= 1'b0;
            end
            else if (page_wr || (fetch_go && page_mode))
            begin
                // Only the offset moves; it sticks at the page end
                if (ofs == `DEWC_OFS_LAST)
                    ofs_sat <= 1'b1;
                else
                    addr_low[3:0] <= ofs + 4'h1;
            end
        end
    end

    // ****************************************
    // Data register
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            data_reg <= `DEWC_RST_BYTE;
        else if (state == DEWC_IDLE)
        begin
            if (fetch_go)
                data_reg <= mem[full_addr];
            else if (i_data_wr && !(page_mode && ofs_sat))
                data_reg <= i_wdata;
        end
    end

    // ****************************************
    // Page buffer
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            prog_arm_q <= 1'b0;
            wipe_arm_q <= 1'b0;
            buf_tag    <= '0;
            for (int i = 0; i < `DEWC_PAGE_BYTES; i++)
                page_buf[i] <= `DEWC_RST_BYTE;
        end
        else
        begin
            prog_arm_q <= prog_arm;
            wipe_arm_q <= wipe_arm;
            // A rising arm leaves the buffer alone
            if (arm_fall)
            begin
                buf_tag <= '0;
                for (int i = 0; i < `DEWC_PAGE_BYTES; i++)
                    page_buf[i] <= `DEWC_RST_BYTE;
            end
            else if (page_wr)
            begin
                page_buf[ofs] <= i_wdata;
                buf_tag[ofs]  <= 1'b1;
            end
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wipe_arm       <= 1'b0;
            wipe_go        <= 1'b0;
            page_mode      <= 1'b0;
            prog_arm       <= 1'b0;
            prog_go        <= 1'b0;
            fetch_arm      <= 1'b0;
            fetch_go       <= 1'b0;
            prog_arm_fresh <= 1'b0;
            wipe_arm_fresh <= 1'b0;
        end
        else
        begin
            // Arm counts as fresh for exactly the next instruction
            prog_arm_fresh <= ctrl_we && !prog_arm
                              && i_wdata[`DEWC_B_PROG_ARM];
            wipe_arm_fresh <= ctrl_we && !wipe_arm
                              && i_wdata[`DEWC_B_WIPE_ARM];
            if (fetch_go)
                fetch_go <= 1'b0;
            if (cyc_end)
            begin
                if (op == DEWC_OP_PAGE_WIPE)
                begin
                    wipe_go  <= 1'b0;
                    wipe_arm <= 1'b0;
                end
                else
                begin
                    prog_go  <= 1'b0;
                    prog_arm <= 1'b0;
                end
            end
            else if (ctrl_we)
            begin
                page_mode <= i_wdata[`DEWC_B_MODE];
                prog_arm  <= i_wdata[`DEWC_B_PROG_ARM];
                wipe_arm  <= i_wdata[`DEWC_B_WIPE_ARM];
                fetch_arm <= i_wdata[`DEWC_B_FETCH_ARM];
                // Program and erase start bits stick only in the cycle after arming
                prog_go   <= i_wdata[`DEWC_B_PROG_GO]
                             && prog_arm && prog_arm_fresh;
                wipe_go   <= i_wdata[`DEWC_B_WIPE_GO]
                             && wipe_arm && wipe_arm_fresh;
                fetch_go  <= i_wdata[`DEWC_B_FETCH_GO]
                             && fetch_arm && !fetch_go;
            end
        end
    end

    // ****************************************
    // Cycle sequencer
    // ****************************************
    // Four-phase talk with the timer: run high until its end is seen,
    // then wait for the end to drop before idling or the next phase.
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            state <= DEWC_IDLE;
            op    <= DEWC_OP_BYTE_PROG;
            again <= 1'b0;
        end
        else
        begin
            case (state)
                DEWC_IDLE:
                begin
                    if (prog_go)
                    begin
                        state <= DEWC_RUN;
                        if (page_mode)
                            op <= DEWC_OP_PAGE_PROG;
                        else
                            op <= DEWC_OP_BYTE_ERASE;
                    end
                    else if (wipe_go)
                    begin
                        state <= DEWC_RUN;
                        op    <= DEWC_OP_PAGE_WIPE;
                    end
                end
                DEWC_RUN:
                begin
                    if (done_rise)
                    begin
                        state <= DEWC_DROP;
                        again <= (op == DEWC_OP_BYTE_ERASE);
                        if (op == DEWC_OP_BYTE_ERASE)
                            op <= DEWC_OP_BYTE_PROG;
                    end
                end
                DEWC_DROP:
                begin
                    if (!done_s2)
                    begin
                        again <= 1'b0;
                        if (again)
                            state <= DEWC_RUN;
                        else
                            state <= DEWC_IDLE;
                    end
                end
                default:
                    state <= DEWC_IDLE;
            endcase
        end
    end

    // ****************************************
    // Array update at each timer end
    // ****************************************
    always_ff @(posedge i_clk)
    begin
        if ((state == DEWC_RUN) && done_rise)
        begin
            case (op)
                DEWC_OP_BYTE_ERASE:
                    mem[full_addr] <= `DEWC_RST_BYTE;
                DEWC_OP_BYTE_PROG:
                    mem[full_addr] <= data_reg;
                DEWC_OP_PAGE_PROG:
                    for (int i = 0; i < `DEWC_PAGE_BYTES; i++)
                        if (buf_tag[i])
                            mem[page_addr(full_addr, 4'(i))]
                                <= page_buf[i];
                DEWC_OP_PAGE_WIPE:
                    for (int i = 0; i < `DEWC_PAGE_BYTES; i++)
                        if (buf_tag[i])
                            mem[page_addr(full_addr, 4'(i))]
                                <= `DEWC_RST_BYTE;
                default:
                    ;
            endcase
        end
    end

    // ****************************************
    // Completion flag
    // ****************************************
    always_ff @(posedge i_clk or posedge i_rst)
    begin
        if (i_rst)
            irq_flag <= 1'b0;
        else if (cyc_end)
            irq_flag <= 1'b1;
        else if (i_irq_ack)
            irq_flag <= 1'b0;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign o_timer_run    = (state == DEWC_RUN);
    assign o_busy         = (state != DEWC_IDLE);
    assign o_nv_irq_flag  = irq_flag;
    assign o_irq_vector   = irq_flag && i_nv_irq_enable && i_mf_irq_enable
                            && i_global_irq_gate && !i_stack_full;
    assign o_nv_addr_high = {{(8-`DEWC_HIGH_W){1'b0}}, addr_high};
    assign o_nv_addr_low  = addr_low;
    assign o_nv_data_reg  = data_reg;
    assign o_nv_control_reg = {1'b0, wipe_arm, wipe_go, page_mode,
                               prog_arm, prog_go, fetch_arm, fetch_go};
    assign o_sector_pointer_high     = sector;
    assign o_alt_sector_pointer_high = alt_sector;

endmodule

`default_nettype wire

/* bench/dewc_core_checker.sv */
// Port assertions for the data EEPROM write control block
`timescale 1ns/10ps
`default_nettype none

module dewc_core_checker
#(
    parameter int DEPTH = 1024
)
(
    // Clock and reset
    input wire logic       i_clk,
    input wire logic       i_rst,
    // CPU register writes
    input wire logic [7:0] i_wdata,
    input wire logic       i_addr_high_wr,
    input wire logic       i_addr_low_wr,
    input wire logic       i_data_wr,
    input wire logic       i_ctrl_wr,
    input wire logic       i_ctrl_via_alt,
    input wire logic       i_sector_wr,
    input wire logic       i_alt_sector_wr,
    // Interrupt controller side
    input wire logic       i_nv_irq_enable,
    input wire logic       i_mf_irq_enable,
    input wire logic       i_global_irq_gate,
    input wire logic       i_stack_full,
    input wire logic       i_irq_ack,
    // Program timer
    input wire logic       i_timer_done,
    input wire logic       o_timer_run,
    // Register contents
    input wire logic [7:0] o_nv_addr_high,
    input wire logic [7:0] o_nv_addr_low,
    input wire logic [7:0] o_nv_data_reg,
    input wire logic [7:0] o_nv_control_reg,
    input wire logic [7:0] o_sector_pointer_high,
    input wire logic [7:0] o_alt_sector_pointer_high,
    // Status and interrupt
    input wire logic       o_busy,
    input wire logic       o_nv_irq_flag,
    input wire logic       o_irq_vector
);
    // ****************************************
    // Helpers
    // ****************************************
    logic [7:0] sel;
    logic       acc;
    assign sel = i_ctrl_via_alt ? o_alt_sector_pointer_high
                                : o_sector_pointer_high;
    // A control write only lands through a sector 1 pointer while idle
    assign acc = i_ctrl_wr && !o_busy && (sel == 8'h01);

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);

    // ****************************************
    // Assertions
    // ****************************************
    reset_vals_a: assert property (
        disable iff (1'b0) i_rst |->
        o_nv_control_reg == 8'h00 && o_sector_pointer_high == 8'h00 &&
        o_alt_sector_pointer_high == 8'h00 && !o_nv_irq_flag)
        else $error("registers not cleared in reset");
    start_no_arm_a: assert property (
        acc && i_wdata[2] && !o_nv_control_reg[3] |=> !o_nv_control_reg[2])
        else $error("start taken without arm");
    arm_start_a: assert property (
        acc && i_wdata[3] && !o_nv_control_reg[3] ##1
        acc && i_wdata[3:2] == 2'b11 |=> o_nv_control_reg[2])
        else $error("start right after arm not taken");
    done_clears_a: assert property ($fell(o_nv_control_reg[2]) |->
        !o_nv_control_reg[3] ##1 o_nv_irq_flag)
        else $error("cycle end did not clear arm or set flag");
    sync_delay_a: assert property (
        o_timer_run && $rose(i_timer_done) |=>
        o_timer_run ##[1:4] !o_timer_run)
        else $error("timer end not seen through synchroniser");
    irq_vector_a: assert property (o_irq_vector == (o_nv_irq_flag &&
        i_nv_irq_enable && i_mf_irq_enable && i_global_irq_gate &&
        !i_stack_full))
        else $error("vector gating wrong");
    irq_ack_a: assert property (
        i_irq_ack && !o_busy |=> !o_nv_irq_flag)
        else $error("flag not cleared by service");
    page_step_a: assert property (i_data_wr && !o_busy &&
        o_nv_control_reg[4] && !i_addr_low_wr &&
        o_nv_addr_low[3:0] != 4'hf |=>
        o_nv_addr_low == $past(o_nv_addr_low) + 8'h01 &&
        o_nv_data_reg == $past(i_wdata))
        else $error("page data write did not step offset");
    sector_guard_a: assert property (
        i_ctrl_wr && sel != 8'h01 && !o_busy && !o_nv_control_reg[0]
        |=> $stable(o_nv_control_reg))
        else $error("control written from wrong sector");
    read_done_a: assert property (
        acc && i_wdata[0] && o_nv_control_reg[1] |=>
        o_nv_control_reg[0] ##1 !o_nv_control_reg[0])
        else $error("read start not cleared in time");

    // ****************************************
    // Coverage
    // ****************************************
    prog_end_c: cover property ($fell(o_nv_control_reg[2]));
    wipe_end_c: cover property ($fell(o_nv_control_reg[5]));
    vector_c: cover property (o_irq_vector);
endmodule

bind dewc_core dewc_core_checker #(.DEPTH(DEPTH)) dewc_core_checker_i (.*);

`default_nettype wire

/* bench/dewc_core_bench.sv */
// Self-checking bench for the data EEPROM write control block
`timescale 1ns/10ps
`default_nettype none

module dewc_core_bench;
    // ****************************************
    // Signals
    // ****************************************
    logic       i_clk, i_rst, i_addr_high_wr, i_addr_low_wr, i_data_wr;
    logic       i_ctrl_wr, i_ctrl_via_alt, i_sector_wr, i_alt_sector_wr;
    logic       i_nv_irq_enable, i_mf_irq_enable, i_global_irq_gate;
    logic       i_stack_full, i_irq_ack, i_timer_done, o_timer_run;
    logic       o_busy, o_nv_irq_flag, o_irq_vector;
    logic [7:0] i_wdata, o_nv_addr_high, o_nv_addr_low, o_nv_data_reg;
    logic [7:0] o_nv_control_reg, o_sector_pointer_high;
    logic [7:0] o_alt_sector_pointer_high;
    logic [5:0] stb;
    int         failures, checked, cycles;

    localparam logic [5:0] AH = 6'h20, AL = 6'h10, DT = 6'h08;
    localparam logic [5:0] CT = 6'h04, SP = 6'h02, AP = 6'h01;

    assign {i_addr_high_wr, i_addr_low_wr, i_data_wr, i_ctrl_wr,
            i_sector_wr, i_alt_sector_wr} = stb;

    dewc_core dewc_core_i (.*);

    always #10 i_clk = ~i_clk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp)
        begin
            failures++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // One register write per instruction cycle, launched at the falling edge
    task automatic cyc(input logic [5:0] s, input logic [7:0] d);
        @(negedge i_clk);
        stb = s;
        i_wdata = d;
    endtask

    task automatic idle;
        cyc(6'h00, 8'h00);
    endtask

    task automatic rd(input logic [7:0] md, input logic [7:0] exp);
        cyc(CT, md | 8'h02);
        cyc(CT, md | 8'h03);
        idle;
        repeat (2) @(negedge i_clk);
        chk(o_nv_control_reg & 8'h01, 8'h00);
        chk(o_nv_data_reg, exp);
    endtask

    // Plays the asynchronous timer: n run/done handshakes, then idle
    task automatic tmr(input int n);
        int k;
        int p;
        for (p = 0; p < n; p++)
        begin
            for (k = 0; k < 40 && o_timer_run !== 1'b1; k++) @(negedge i_clk);
            chk({7'h00, o_timer_run}, 8'h01);
            repeat (3) @(negedge i_clk);
            i_timer_done = 1'b1;
            for (k = 0; k < 40 && o_timer_run !== 1'b0; k++) @(negedge i_clk);
            i_timer_done = 1'b0;
        end
        for (k = 0; k < 40 && o_busy !== 1'b0; k++) @(negedge i_clk);
        chk({7'h00, o_busy}, 8'h00);
    endtask

    task automatic end_sim;
        if (failures == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        chk(o_nv_control_reg, 8'h00);
        chk(o_sector_pointer_high | o_alt_sector_pointer_high, 8'h00);
    endtask

    task automatic t_guard;
        cyc(CT, 8'h02);
        idle;
        chk(o_nv_control_reg, 8'h00);
        i_ctrl_via_alt = 1'b1;
        cyc(SP, 8'h01);
        cyc(CT, 8'h02);
        idle;
        chk(o_nv_control_reg, 8'h00);
        cyc(AP, 8'h01);
        cyc(CT, 8'h02);
        idle;
        chk(o_nv_control_reg, 8'h02);
        i_ctrl_via_alt = 1'b0;
        cyc(CT, 8'h00);
        idle;
        chk(o_nv_control_reg, 8'h00);
    endtask

    task automatic t_start;
        cyc(CT, 8'h04);
        cyc(CT, 8'h0c);
        idle;
        chk(o_nv_control_reg, 8'h08);
        cyc(CT, 8'h00);
        cyc(CT, 8'h08);
        idle;
        cyc(CT, 8'h0c);
        idle;
        chk(o_nv_control_reg, 8'h08);
        cyc(CT, 8'h00);
        cyc(CT, 8'h40);
        idle;
        cyc(CT, 8'h60);
        idle;
        chk(o_nv_control_reg, 8'h40);
        cyc(CT, 8'h00);
    endtask

    task automatic t_byte;
        cyc(AH, 8'h02);
        cyc(AL, 8'h35);
        cyc(DT, 8'ha5);
        i_global_irq_gate = 1'b0;
        cyc(CT, 8'h08);
        cyc(CT, 8'h0c);
        idle;
        i_global_irq_gate = 1'b1;
        chk(o_nv_control_reg, 8'h0c);
        tmr(2);
        chk(o_nv_control_reg, 8'h00);
        chk({7'h00, o_nv_irq_flag}, 8'h01);
        rd(8'h00, 8'ha5);
    endtask

    task automatic t_irq;
        int k;
        for (k = 0; k < 16; k++)
        begin
            @(negedge i_clk);
            {i_nv_irq_enable, i_mf_irq_enable, i_global_irq_gate} = 3'(k);
            i_stack_full = ~k[3];
            #1 chk({7'h00, o_irq_vector}, {7'h00, k == 15});
        end
        @(negedge i_clk);
        i_irq_ack = 1'b1;
        @(negedge i_clk);
        i_irq_ack = 1'b0;
        chk({7'h00, o_nv_irq_flag}, 8'h00);
    endtask

    // Each start write is followed by an idle cycle: a held control write
    // would be taken again and drop the start bit before the cycle ends.
    task automatic t_page;
        int i;
        cyc(CT, 8'h10);
        cyc(AH, 8'h01);
        cyc(AL, 8'h00);
        for (i = 0; i < 16; i++) cyc(DT, 8'hff);
        cyc(CT, 8'h50);
        cyc(CT, 8'h70);
        idle;
        tmr(1);
        chk(o_nv_control_reg, 8'h10);
        chk({7'h00, o_nv_irq_flag}, 8'h01);
        cyc(AL, 8'h00);
        rd(8'h10, 8'h00);
        cyc(AL, 8'h00);
        for (i = 0; i < 17; i++)
        begin
            cyc(DT, 8'(8'h20 + i));
            idle;
            chk(o_nv_addr_low, (i < 15) ? 8'(i + 1) : 8'h0f);
            chk(o_nv_data_reg, (i < 16) ? 8'(8'h20 + i) : 8'h2f);
        end
        cyc(CT, 8'h18);
        cyc(CT, 8'h1c);
        idle;
        tmr(1);
        chk(o_nv_control_reg, 8'h10);
        // Buffer loaded, then dropped by arm falling: program must be empty
        cyc(AL, 8'h00);
        cyc(DT, 8'h77);
        cyc(DT, 8'h77);
        cyc(CT, 8'h18);
        cyc(CT, 8'h10);
        cyc(CT, 8'h18);
        cyc(CT, 8'h1c);
        idle;
        tmr(1);
        cyc(AL, 8'h00);
        for (i = 0; i < 16; i++) rd(8'h10, 8'(8'h20 + i));
        chk(o_nv_addr_high, 8'h01);
        chk(o_nv_addr_low, 8'h0f);
        cyc(CT, 8'h00);
        idle;
    endtask

    // ****************************************
    // Run control
    // ****************************************
    always @(posedge i_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            failures++;
            end_sim;
        end
    end

    initial
    begin
        {i_clk, i_ctrl_via_alt, i_nv_irq_enable, i_mf_irq_enable} = 4'h0;
        {i_global_irq_gate, i_stack_full, i_irq_ack, i_timer_done} = 4'h0;
        {failures, checked, cycles} = '0;
        stb = 6'h00;
        i_wdata = 8'h00;
        i_rst = 1'b1;
        repeat (4) @(posedge i_clk);
        @(negedge i_clk);
        i_rst = 1'b0;
        t_reset;
        t_guard;
        t_start;
        t_byte;
        t_irq;
        t_page;
        end_sim;
    end
endmodule

`default_nettype wire
